// File: design/ppp_map.svh
// Purpose: register offsets, field positions, reset values and counts of the printer port
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH

// i/o addresses, data register and sense port share one address, control and status another
`define PPP_LOCAL_DATA_ADDR 16'h0250
`define PPP_LOCAL_CTL_ADDR 16'h0260
`define PPP_SHARED_DATA_ADDR 16'h028a
`define PPP_SHARED_CTL_ADDR 16'h028c

// control register fields
`define PPP_CTL_STROBE 0
`define PPP_CTL_AUTO_NEWLINE 1
`define PPP_CTL_REINIT 2
`define PPP_CTL_SELECT 3
`define PPP_CTL_DRIVE_OFF 4
`define PPP_CTL_IRQ_OFF 7

// status port fields
`define PPP_STAT_OCCUPIED 0
`define PPP_STAT_ACK 1
`define PPP_STAT_ERROR 2
`define PPP_STAT_MEDIA_OUT 3
`define PPP_STAT_ONLINE 4
`define PPP_STAT_STROBE 5
`define PPP_STAT_REINIT 6
`define PPP_STAT_SELECT 7

// reset values and the value read at unmapped addresses
`define PPP_CTL_RESET 8'h90
`define PPP_DATA_RESET 8'h00
`define PPP_UNMAPPED_READ 8'h00

// interrupt request lines served by the two ports
`define PPP_LOCAL_IRQ_LINE 6
`define PPP_SHARED_IRQ_LINE 2

// request queue depth
`define PPP_QUEUE_DEPTH 16

`endif

// File: design/ppp_pkg.sv
// Purpose: types shared by the printer port design files
// Assumes: used with package-qualified names only
// Notes: pin groups and queue entries travel as packed structs
package ppp_pkg;

   // connector levels as seen on the pins, 1 is high
   typedef struct packed {
      logic [7:0] data;
      logic select;
      logic reinit;
      logic strobe;
      logic online;
      logic media_out;
      logic error;
      logic ack;
      logic occupied;
   } ppp_pins_in_t;

   // pin drives; line bits are open drain, order strobe, auto_newline, reinit, select
   typedef struct packed {
      logic [7:0] data_out;
      logic [7:0] data_oe;
      logic [3:0] line_out;
      logic [3:0] line_oe;
   } ppp_pins_out_t;

   // one queued host access
   typedef struct packed {
      logic hit;
      logic shared;
      logic is_ctl;
      logic is_read;
      logic [7:0] wdata;
   } ppp_entry_t;

   typedef struct packed {
      logic [7:0] data_drive;
      logic [7:0] line_control;
   } ppp_regs_t;

   typedef enum logic [1:0] {
      PPP_RUN = 2'b01,
      PPP_HOLD = 2'b10
   } ppp_mode_t;

endpackage

// File: design/ppp_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs come from outside the clock domain
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ps
module ppp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } ppp_sync_state_t;

   ppp_sync_state_t st;
   ppp_sync_state_t next_st;

   always_comb
   begin
      next_st.stage1 = d;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign q = st.stage2;
endmodule // ppp_sync

// File: design/ppp_fifo.sv
// Purpose: request queue between the host i/o strobes and the register logic
// Assumes: one push and one pop at most per cycle
// Notes: full is a flip-flop so in_ready is glitch free
`timescale 1ns/1ps
module ppp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic full;
   } ppp_fifo_state_t;

   ppp_fifo_state_t st;
   ppp_fifo_state_t next_st;
   logic push;
   logic pop;

   assign in_ready = ~st.full;
   assign out_valid = (st.count != '0);
   assign out_data = st.mem[st.rptr];
   assign push = in_valid & ~st.full;
   assign pop = out_ready & out_valid;

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wptr] = in_data;
         next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + AW'(1);
      end
      if (pop)
         next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + AW'(1);
      if (push && !pop)
         next_st.count = st.count + (AW+1)'(1);
      else if (pop && !push)
         next_st.count = st.count - (AW+1)'(1);
      next_st.full = (next_st.count == (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end
endmodule // ppp_fifo

// File: design/ppp_top.sv
// Purpose: two eight-bit parallel printer ports, local and shared unit, behind i/o-mapped registers
// Assumes: one 100 MHz clock, host i/o strobes synchronous to it, pins asynchronous
// Notes: host accesses pass a 16-entry queue; shared accesses wait for the reservation grant
//
// Notes on behaviour
// - drivers enabled: each data register bit drives its pin, 1 high, 0 low
// - control bits 0-3 pull strobe, auto_newline, reinit, select pins low
// - control bit 4 set floats data drivers; clear enables them
// - control bit 7 clear enables interrupt while printer-occupied pin is low
// - every status bit reads the inverse of its pin level at read time
// - low five status bits are inputs; high three read back control pins
// - status bits: occupied, ack, error, media_out, online, strobe, reinit, select
// - local port interrupt is line 6, shared unit port interrupt line 2
// - a granted reservation keeps the shared port exclusive until released
`timescale 1ns/1ps
`include "ppp_map.svh"
module ppp_top #(
   parameter int QUEUE_DEPTH = `PPP_QUEUE_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host i/o access
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic io_ready,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   // local connector
   input wire ppp_pkg::ppp_pins_in_t local_pins_in,
   output ppp_pkg::ppp_pins_out_t local_pins_out,
   output logic irq_line_local,
   // shared unit connector
   input wire ppp_pkg::ppp_pins_in_t shared_pins_in,
   output ppp_pkg::ppp_pins_out_t shared_pins_out,
   output logic irq_line_shared,
   // shared unit reservation
   input wire logic share_want,
   output logic share_req,
   input wire logic share_gnt
);
   typedef struct packed {
      ppp_pkg::ppp_mode_t mode;
      ppp_pkg::ppp_regs_t [1:0] regs;
      ppp_pkg::ppp_pins_out_t [1:0] pins_out;
      logic [1:0] irq;
      logic [7:0] rdata;
      logic rvalid;
      logic req;
   } ppp_state_t;

   ppp_state_t st;
   ppp_state_t next_st;

   ppp_pkg::ppp_pins_in_t [1:0] pins;
   ppp_pkg::ppp_entry_t push_entry;
   ppp_pkg::ppp_entry_t head;
   logic push_valid;
   logic queue_ready;
   logic head_valid;
   logic take;
   logic gnt;

   // pins cross into the clock domain before anything looks at them
   ppp_sync #(
      .WIDTH($bits(ppp_pkg::ppp_pins_in_t))
   ) u_sync_local (
      .clk(clk),
      .rst_n(rst_n),
      .d(local_pins_in),
      .q(pins[0])
   );

   ppp_sync #(
      .WIDTH($bits(ppp_pkg::ppp_pins_in_t))
   ) u_sync_shared (
      .clk(clk),
      .rst_n(rst_n),
      .d(shared_pins_in),
      .q(pins[1])
   );

   ppp_sync #(
      .WIDTH(1)
   ) u_sync_gnt (
      .clk(clk),
      .rst_n(rst_n),
      .d(share_gnt),
      .q(gnt)
   );

   // status byte of one port; every bit is the inverted pin level
   function automatic logic [7:0] status_of(input ppp_pkg::ppp_pins_in_t p);
      logic [7:0] s;
      s = '0;
      s[`PPP_STAT_OCCUPIED] = ~p.occupied;
      s[`PPP_STAT_ACK] = ~p.ack;
      s[`PPP_STAT_ERROR] = ~p.error;
      s[`PPP_STAT_MEDIA_OUT] = ~p.media_out;
      s[`PPP_STAT_ONLINE] = ~p.online;
      s[`PPP_STAT_STROBE] = ~p.strobe;
      s[`PPP_STAT_REINIT] = ~p.reinit;
      s[`PPP_STAT_SELECT] = ~p.select;
      return s;
   endfunction

   // address decode of a host access into a queue entry
   always_comb
   begin
      push_entry = '0;
      push_entry.is_read = io_rd;
      push_entry.wdata = io_wdata;
      push_valid = io_rd | io_wr;
      if (io_addr == `PPP_LOCAL_DATA_ADDR)
      begin
         push_entry.hit = 1'b1;
      end
      else if (io_addr == `PPP_LOCAL_CTL_ADDR)
      begin
         push_entry.hit = 1'b1;
         push_entry.is_ctl = 1'b1;
      end
      else if (io_addr == `PPP_SHARED_DATA_ADDR)
      begin
         push_entry.hit = 1'b1;
         push_entry.shared = 1'b1;
      end
      else if (io_addr == `PPP_SHARED_CTL_ADDR)
      begin
         push_entry.hit = 1'b1;
         push_entry.shared = 1'b1;
         push_entry.is_ctl = 1'b1;
      end
   end

   ppp_fifo #(
      .WIDTH($bits(ppp_pkg::ppp_entry_t)),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push_valid),
      .in_ready(queue_ready),
      .in_data(push_entry),
      .out_valid(head_valid),
      .out_ready(take),
      .out_data(head)
   );

   // a queued shared access stalls the whole queue until the grant is held;
   // this keeps host order but lets a long wait fill the queue and stop the host
   always_comb
   begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.req = share_want;
      take = 1'b0;
      case (st.mode)
         ppp_pkg::PPP_RUN:
         begin
            if (head_valid)
            begin
               if (head.hit && head.shared && !gnt)
                  next_st.mode = ppp_pkg::PPP_HOLD;
               else
                  take = 1'b1;
            end
         end
         ppp_pkg::PPP_HOLD:
         begin
            if (gnt)
            begin
               take = 1'b1;
               next_st.mode = ppp_pkg::PPP_RUN;
            end
         end
         default:
         begin
            next_st.mode = ppp_pkg::PPP_RUN;
         end
      endcase

      if (take)
      begin
         if (head.is_read)
         begin
            next_st.rvalid = 1'b1;
            if (!head.hit)
               next_st.rdata = `PPP_UNMAPPED_READ;
            else if (head.is_ctl)
               next_st.rdata = status_of(pins[head.shared]);
            else if (st.regs[head.shared].line_control[`PPP_CTL_DRIVE_OFF])
               next_st.rdata = pins[head.shared].data;
            else
               next_st.rdata = st.regs[head.shared].data_drive;
         end
         else if (head.hit)
         begin
            if (head.is_ctl)
               next_st.regs[head.shared].line_control = head.wdata;
            else
               next_st.regs[head.shared].data_drive = head.wdata;
         end
      end

      // pin drives follow the registers on the same edge
      for (int p = 0; p < 2; p++)
      begin
         next_st.pins_out[p].data_out = next_st.regs[p].data_drive;
         next_st.pins_out[p].data_oe = {8{~next_st.regs[p].line_control[`PPP_CTL_DRIVE_OFF]}};
         next_st.pins_out[p].line_out = 4'h0;
         next_st.pins_out[p].line_oe = next_st.regs[p].line_control[3:0];
         // level request; the handler has to mask it, acking does nothing
         next_st.irq[p] = ~next_st.regs[p].line_control[`PPP_CTL_IRQ_OFF] & ~pins[p].occupied;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st.mode <= ppp_pkg::PPP_RUN;
         for (int p = 0; p < 2; p++)
         begin
            st.regs[p].data_drive <= `PPP_DATA_RESET;
            st.regs[p].line_control <= `PPP_CTL_RESET;
            st.pins_out[p].data_out <= `PPP_DATA_RESET;
            st.pins_out[p].data_oe <= 8'h00;
            st.pins_out[p].line_out <= 4'h0;
            st.pins_out[p].line_oe <= 4'h0;
         end
         st.irq <= 2'b00;
         st.rdata <= 8'h00;
         st.rvalid <= 1'b0;
         st.req <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign io_ready = queue_ready;
   assign io_rdata = st.rdata;
   assign io_rvalid = st.rvalid;
   assign local_pins_out = st.pins_out[0];
   assign shared_pins_out = st.pins_out[1];
   assign irq_line_local = st.irq[0];
   assign irq_line_shared = st.irq[1];
   assign share_req = st.req;
endmodule // ppp_top

// File: dv/ppp_printer_model.sv
// Purpose: printer standing on one port connector
// Assumes: control lines are open drain with pull-ups
// Notes: occupied rises on strobe, drops BUSY cycles after it ends
`timescale 1ns/1ps
module ppp_printer_model #(
   parameter int BUSY = 30
) (
   // clock
   input wire logic clk,
   // connector
   input wire ppp_pkg::ppp_pins_out_t po,
   output ppp_pkg::ppp_pins_in_t pi,
   // levels: online, media_out, error, ack; data when undriven
   input wire logic [3:0] st,
   input wire logic [7:0] ext
);
   int cnt = 0;
   logic [3:0] lv;
   always @(posedge clk)
      if (!lv[0])
         cnt <= BUSY;
      else if (cnt > 0)
         cnt <= cnt - 1;
   always_comb
   begin
      lv = ~po.line_oe;
      pi.data = (po.data_oe & po.data_out) | (~po.data_oe & ext);
      pi.select = lv[3];
      pi.reinit = lv[2];
      pi.strobe = lv[0];
      {pi.online, pi.media_out, pi.error, pi.ack} = st;
      pi.occupied = cnt > 0;
   end
endmodule // ppp_printer_model

// File: dv/ppp_top_asserts.sv
// Purpose: port checks beside the printer port top
// Assumes: one clock, asynchronous active-low reset
// Notes: pin bounds are loose since pins pass a synchroniser
`timescale 1ns/1ps
module ppp_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host access
   input wire logic [15:0] io_addr,
   input wire logic io_rd,
   input wire logic io_ready,
   input wire logic io_rvalid,
   // connectors
   input wire ppp_pkg::ppp_pins_in_t local_pins_in,
   input wire ppp_pkg::ppp_pins_out_t local_pins_out,
   input wire logic irq_line_local,
   input wire ppp_pkg::ppp_pins_in_t shared_pins_in,
   input wire ppp_pkg::ppp_pins_out_t shared_pins_out,
   input wire logic irq_line_shared,
   // reservation
   input wire logic share_want,
   input wire logic share_req,
   input wire logic share_gnt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_local;
      io_rd && io_ready && (io_addr == 16'h0250 || io_addr == 16'h0260);
   endsequence
   sequence s_busy_l;
      local_pins_in.occupied [*5];
   endsequence
   sequence s_busy_s;
      shared_pins_in.occupied [*5];
   endsequence
   // bound assumes the bench grants a waiting shared access promptly
   property p_rd_answer;
      s_rd_local |-> ##[2:200] io_rvalid;
   endproperty
   property p_open_drain;
      local_pins_out.line_out == 4'h0 && shared_pins_out.line_out == 4'h0;
   endproperty
   property p_drive_whole;
      local_pins_out.data_oe == 8'h00 || local_pins_out.data_oe == 8'hff;
   endproperty
   property p_irq_l;
      s_busy_l |=> !irq_line_local;
   endproperty
   property p_irq_s;
      s_busy_s |=> !irq_line_shared;
   endproperty
   property p_reset_idle;
      $rose(rst_n) |-> !irq_line_local && !irq_line_shared && local_pins_out.line_oe == 4'h0
         && local_pins_out.data_oe == 8'h00;
   endproperty
   property p_req_follow;
      $past(rst_n) |-> share_req == $past(share_want);
   endproperty
   property p_no_gnt;
      !share_gnt [*6] |=> $stable(shared_pins_out);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("local read not answered");
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   a_drive_whole: assert property (p_drive_whole) else $error("data enables split");
   a_irq_l: assert property (p_irq_l) else $error("local irq while occupied");
   a_irq_s: assert property (p_irq_s) else $error("shared irq while occupied");
   a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
   a_req_follow: assert property (p_req_follow) else $error("request not following want");
   a_no_gnt: assert property (p_no_gnt) else $error("shared port moved without grant");
endmodule // ppp_checker
bind ppp_top ppp_checker u_chk (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
   .io_ready(io_ready), .io_rvalid(io_rvalid), .local_pins_in(local_pins_in),
   .local_pins_out(local_pins_out), .irq_line_local(irq_line_local), .shared_pins_in(shared_pins_in),
   .shared_pins_out(shared_pins_out), .irq_line_shared(irq_line_shared), .share_want(share_want),
   .share_req(share_req), .share_gnt(share_gnt));

// File: dv/parallel_printer_port_bench.sv
// Purpose: self-checking bench for the printer port top
// Assumes: queue shrunk to 4 entries so it fills quickly
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module parallel_printer_port_bench;
   typedef struct {logic [15:0] a; logic w; logic [7:0] v; logic [3:0] l; logic o;} ppp_row_t;
   localparam int QD = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic io_ready, io_rvalid, irq_l, irq_s, share_req;
   logic [7:0] io_rdata;
   logic share_want = 1'b0;
   logic share_gnt = 1'b1;
   // online high, media_out low, error high, ack high
   logic [3:0] st = 4'b1011;
   ppp_pkg::ppp_pins_in_t lpi, spi;
   ppp_pkg::ppp_pins_out_t lpo, spo;
   int fail_count = 0;
   int checks = 0;
   int rvn = 0;
   int n, base;
   ppp_row_t rows [16] = '{
      '{16'h0260, 0, 8'h09, 0, 0}, '{16'h0250, 0, 8'h5a, 0, 0}, '{16'h0250, 1, 8'ha5, 0, 0},
      '{16'h0250, 0, 8'h5a, 0, 0}, '{16'h0260, 1, 8'hec, 4'hc, 1}, '{16'h0260, 0, 8'hc9, 0, 0},
      '{16'h0250, 0, 8'ha5, 0, 0}, '{16'h0260, 1, 8'h92, 4'h2, 0}, '{16'h0260, 0, 8'h09, 0, 0},
      '{16'h0252, 0, 8'h00, 0, 0}, '{16'h028c, 1, 8'h98, 4'h8, 0}, '{16'h028c, 0, 8'h89, 0, 0},
      '{16'h028a, 1, 8'h3c, 4'h8, 0}, '{16'h028c, 1, 8'h09, 4'h9, 1}, '{16'h028a, 0, 8'h3c, 0, 0},
      '{16'h028c, 1, 8'h08, 4'h8, 1}};
   ppp_top #(.QUEUE_DEPTH(QD)) uut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_ready(io_ready), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .local_pins_in(lpi), .local_pins_out(lpo), .irq_line_local(irq_l), .shared_pins_in(spi),
      .shared_pins_out(spo), .irq_line_shared(irq_s), .share_want(share_want), .share_req(share_req),
      .share_gnt(share_gnt));
   ppp_printer_model u_lp (.clk(clk), .po(lpo), .pi(lpi), .st(st), .ext(8'h5a));
   ppp_printer_model u_sp (.clk(clk), .po(spo), .pi(spi), .st(st), .ext(8'h5a));
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (io_rvalid === 1'b1)
         rvn <= rvn + 1;
   task automatic end_sim;
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one access; writes compare pin enables, reads the answer
   task automatic acc(input ppp_row_t r);
      ppp_pkg::ppp_pins_out_t p;
      @(negedge clk);
      io_addr = r.a;
      io_wr = r.w;
      io_rd = !r.w;
      io_wdata = r.v;
      @(negedge clk);
      io_wr = 1'b0;
      io_rd = 1'b0;
      n = 0;
      while (!r.w && io_rvalid !== 1'b1 && n < 50)
      begin
         @(negedge clk);
         n++;
      end
      if (r.w)
         repeat (6) @(negedge clk);
      p = (r.a > 16'h0270) ? spo : lpo;
      // a read that never answers must not pass on stale read data
      check(r.w ? {p.line_oe, p.data_oe} : {3'h0, io_rvalid, io_rdata}, r.w ? {r.l, {8{r.o}}} : {4'h1, r.v});
   endtask
   initial
   begin
      #100000;
      fail_count++;
      end_sim();
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      share_want = 1'b1;
      for (int i = 0; i < 16; i++)
         acc(rows[i]);
      repeat (60) @(negedge clk);
      check({10'h0, irq_s, irq_l}, 12'h002);
      check({4'h0, spi.data}, 12'h03c);
      acc('{16'h0250, 1, 8'h41, 4'h2, 0});
      acc('{16'h0260, 1, 8'h89, 4'h9, 1});
      check({4'h0, lpi.data}, 12'h041);
      acc('{16'h0260, 1, 8'h88, 4'h8, 1});
      acc('{16'h0260, 1, 8'h08, 4'h8, 1});
      check({11'h0, irq_l}, 12'h000);
      n = 0;
      while (irq_l !== 1'b1 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      repeat (10) @(negedge clk);
      check({11'h0, irq_l}, 12'h001);
      acc('{16'h0260, 1, 8'h88, 4'h8, 1});
      check({11'h0, irq_l}, 12'h000);
      // shared read blocked without grant fills the queue
      share_gnt = 1'b0;
      repeat (8) @(negedge clk);
      base = rvn;
      io_addr = 16'h028c;
      io_rd = 1'b1;
      n = 0;
      while (io_ready === 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      io_rd = 1'b0;
      check(12'(n), 12'(QD));
      repeat (20) @(negedge clk);
      check(12'(rvn - base), 12'h000);
      share_gnt = 1'b1;
      repeat (40) @(negedge clk);
      check(12'(rvn - base), 12'(QD));
      acc('{16'h0260, 1, 8'h0c, 4'hc, 1});
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      check({lpo.line_oe, lpo.data_oe}, 12'h000);
      rst_n = 1'b1;
      acc(rows[0]);
      end_sim();
   end
endmodule // parallel_printer_port_bench
